// ==== src/rtil_core.sv ====
// Status, interrupt merge, general RAM and power lockout of the clock block
`timescale 1ns/1ps
`default_nettype none
module rtil_core #(
    parameter int RAM_WORDS = 256
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Timebase and events from outside the clock domain
    input  wire logic       timebase,
    input  wire logic       alarm_match,
    input  wire logic       update_done,
    // Power status pins
    input  wire logic       host_rail,
    input  wire logic       power_ok_input,
    input  wire logic       main_rail,
    input  wire logic       battery_rail_fresh,
    input  wire logic       controller_init,
    // Host register port
    input  wire logic       hostRd,
    input  wire logic       hostWr,
    input  wire logic [7:0] hostAddr,
    input  wire logic [7:0] hostWdata,
    // Controller register port
    input  wire logic       ctlRd,
    input  wire logic       ctlWr,
    input  wire logic [7:0] ctlAddr,
    input  wire logic [7:0] ctlWdata,
    // Outputs
    output logic [7:0]      rdData,
    output logic            clock_irq_n,
    output logic            host_write_lockout,
    output logic            controller_write_lockout,
    output logic            oscillatorOn
);
    import rtil_pkg::*;

    initial begin
        if (RAM_WORDS != 256) begin
            $error("rtil_core: RAM_WORDS must be 256");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins
    logic [6:0] syncA_ff;
    logic [6:0] syncB_ff;
    logic [6:0] pinIn;
    assign pinIn = {timebase, alarm_match, update_done, host_rail,
                    power_ok_input, main_rail, controller_init};
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end else begin
            syncA_ff <= pinIn;
            syncB_ff <= syncA_ff;
        end
    end
    logic tbS, alarmS, updS, hostRailS, pgoodS, mainRailS, ctlInitS;
    assign {tbS, alarmS, updS, hostRailS, pgoodS, mainRailS, ctlInitS} = syncB_ff;

    logic battS1_ff, battS2_ff;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            battS1_ff <= 1'b0;
            battS2_ff <= 1'b0;
        end else begin
            battS1_ff <= battery_rail_fresh;
            battS2_ff <= battS1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] ctrlA_ff, nxt_ctrlA;
    logic [7:0] ctrlB_ff, nxt_ctrlB;
    logic [2:0] flags_ff, nxt_flags;       // periodic, alarm, update
    logic [2:0] pend_ff, nxt_pend;         // events deferred during a read
    logic       valid_ff, nxt_valid;
    logic       inRead_ff, nxt_inRead;
    logic [2:0] tbHist_ff, nxt_tbHist;
    logic [5:0] lockCnt_ff, nxt_lockCnt;
    logic       hostLock_ff, nxt_hostLock;
    logic       ctlLock_ff, nxt_ctlLock;
    logic       freshBatt_ff, nxt_freshBatt;
    logic       irqN_ff, nxt_irqN;
    logic       oscOn_ff, nxt_oscOn;
    logic [7:0] rd_ff, nxt_rd;
    logic       nxt_hostPowOk;
    logic [7:0] ram_ff [RAM_WORDS];

    logic tbTick, tbRise, periodicEv, secondEv, divRun;
    assign tbRise = tbS && !tbHist_ff[0];
    assign tbTick = tbRise && oscOn_ff;
    // Oscillator off and reset divider settings hold the chain
    assign divRun = oscOn_ff && (ctrlA_ff[6:5] != 2'b00) &&
                    (ctrlA_ff[6:4] != DIV_RESET_MSB) && (ctrlA_ff[6:4] != 3'h7);

    rtil_divider #(.STAGES(DIV_STAGES)) u_div (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .tbTick        (tbTick),
        .divRun        (divRun),
        .rateSelect    (ctrlA_ff[RATE_LSB +: 4]),
        .periodicEvent (periodicEv),
        .secondEvent   (secondEv)
    );

    function automatic logic isRam(input logic [7:0] a);
        return (a >= RAM_BANK1_LO && a <= RAM_BANK1_HI) ||
               (a >= RAM_BANK2_LO && a <= RAM_BANK2_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Access arbitration: host has priority when both request
    logic       anyRd, anyWr, wrOk;
    logic [7:0] acAddr, acWdata;
    logic [2:0] events;
    assign anyRd   = hostRd || (!hostWr && ctlRd);
    assign acAddr  = (hostRd || hostWr) ? hostAddr : ctlAddr;
    assign acWdata = hostWr ? hostWdata : ctlWdata;
    assign wrOk    = hostWr ? !hostLock_ff : (ctlWr && !ctlLock_ff && !hostRd);
    assign anyWr   = (hostWr || ctlWr) && wrOk;

    always_comb begin
        nxt_ctrlA     = ctrlA_ff;
        nxt_ctrlB     = ctrlB_ff;
        nxt_valid     = valid_ff;
        nxt_rd        = rd_ff;
        nxt_inRead    = anyRd && acAddr == REG_FLAGS;
        nxt_tbHist    = {tbHist_ff[1:0], tbS};
        nxt_freshBatt = freshBatt_ff;
        nxt_oscOn     = oscOn_ff;
        // alarm match pulses from the time compare, once a second
        // events set flags independent of enables
        events        = {periodicEv, alarmS && secondEv, updS && secondEv};
        nxt_flags     = flags_ff;
        nxt_pend      = pend_ff;
        if (anyRd) begin
            unique case (acAddr)
                REG_CTRL_A: nxt_rd = ctrlA_ff;
                REG_CTRL_B: nxt_rd = ctrlB_ff;
                REG_FLAGS:  nxt_rd = {!irqN_ff, flags_ff, 4'h0};
                REG_VALID:  nxt_rd = {valid_ff, 7'h00};
                default:    nxt_rd = isRam(acAddr) ? ram_ff[acAddr] : 8'h00;
            endcase
        end
        // valid bit sets by reading its register
        if (anyRd && acAddr == REG_VALID) begin
            nxt_valid = 1'b1;
        end
        // held events merge after the read
        if (nxt_inRead || inRead_ff) begin
            nxt_pend = pend_ff | events;
            // read clears only bits returned high
            if (anyRd && acAddr == REG_FLAGS) begin
                nxt_flags = 3'h0;
            end
        end else begin
            nxt_flags = flags_ff | events | pend_ff;
            nxt_pend  = 3'h0;
        end
        // writes to valid register have no effect
        if (anyWr && acAddr == REG_CTRL_A) begin
            nxt_ctrlA = {1'b0, acWdata[6:0]};
        end
        if (anyWr && acAddr == REG_CTRL_B) begin
            nxt_ctrlB = {acWdata[7:4], 1'b0, acWdata[2:1], 1'b0};
            if (acWdata[7]) begin
                nxt_ctrlB[UPDATE_BIT] = 1'b0;
            end
        end
        // fresh battery clears the valid bit
        // new battery stops oscillator until main power
        if (battS2_ff) begin
            nxt_valid     = 1'b0;
            nxt_oscOn     = 1'b0;
            nxt_freshBatt = 1'b1;
        end else if (freshBatt_ff && mainRailS) begin
            nxt_freshBatt = 1'b0;
            nxt_oscOn     = 1'b1;
            nxt_ctrlA     = 8'h00;
            nxt_ctrlB     = 8'h00;
        end
    end

    always_comb begin
        // enables at control bits 6..4
        // Next-state terms let an enable write drive the line on its own edge
        // pending flag plus enable asserts at once
        // held while any pair is set
        nxt_irqN = !(|(nxt_flags & nxt_ctrlB[UPDATE_BIT +: 3]));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power lockout
    always_comb begin
        nxt_hostPowOk = hostRailS && pgoodS;
        nxt_lockCnt   = lockCnt_ff;
        // controller lockout from rail and init
        nxt_ctlLock   = !mainRailS || ctlInitS;
        nxt_hostLock  = hostLock_ff;
        if (!nxt_hostPowOk) begin
            // Reloaded while power is bad so in normal mode with valid time every dip restarts the full window
            nxt_hostLock = 1'b1;
            // timed part only in normal mode with valid time
            nxt_lockCnt  = (ctrlA_ff[DIV_LSB +: 3] == DIV_NORMAL && valid_ff) ?
                           LOCKOUT_TICKS : 6'h00;
        end else if (lockCnt_ff != 6'h00) begin
            if (tbRise) begin
                nxt_lockCnt = lockCnt_ff - 6'h01;
            end
        end else begin
            // Host never opens ahead of the controller after a joint power-up
            // also wait for controller init
            nxt_hostLock = nxt_ctlLock;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrlA_ff     <= CTRL_A_RST;
            ctrlB_ff     <= CTRL_B_RST;
            flags_ff     <= 3'h0;
            pend_ff      <= 3'h0;
            valid_ff     <= 1'b0;
            inRead_ff    <= 1'b0;
            tbHist_ff    <= 3'h0;
            lockCnt_ff   <= 6'h00;
            hostLock_ff  <= 1'b1;
            ctlLock_ff   <= 1'b1;
            freshBatt_ff <= 1'b0;
            irqN_ff      <= 1'b1;
            oscOn_ff     <= 1'b1;
            rd_ff        <= 8'h00;
        end else begin
            ctrlA_ff     <= nxt_ctrlA;
            ctrlB_ff     <= nxt_ctrlB;
            flags_ff     <= nxt_flags;
            pend_ff      <= nxt_pend;
            valid_ff     <= nxt_valid;
            inRead_ff    <= nxt_inRead;
            tbHist_ff    <= nxt_tbHist;
            lockCnt_ff   <= nxt_lockCnt;
            hostLock_ff  <= nxt_hostLock;
            ctlLock_ff   <= nxt_ctlLock;
            freshBatt_ff <= nxt_freshBatt;
            irqN_ff      <= nxt_irqN;
            oscOn_ff     <= nxt_oscOn;
            rd_ff        <= nxt_rd;
        end
    end

    // battery RAM in two banks, no reset so contents persist
    // update cycle never blocks RAM access
    always_ff @(posedge ref_clk) begin
        if (anyWr && isRam(acAddr)) begin
            ram_ff[acAddr] <= acWdata;
        end
    end

    assign rdData                   = rd_ff;
    assign clock_irq_n              = irqN_ff;
    assign host_write_lockout       = hostLock_ff;
    assign controller_write_lockout = ctlLock_ff;
    assign oscillatorOn             = oscOn_ff;
endmodule
`default_nettype wire

// ==== src/rtil_pkg.sv ====
// Package: register map, field positions, reset values and timing counts
package rtil_pkg;
    // Register indexes on the 8-bit internal register port
    localparam logic [7:0] REG_CTRL_A     = 8'h0A;
    localparam logic [7:0] REG_CTRL_B     = 8'h0B;
    localparam logic [7:0] REG_FLAGS      = 8'h0C;
    localparam logic [7:0] REG_VALID      = 8'h0D;
    localparam logic [7:0] RAM_BANK1_LO   = 8'h0E;
    localparam logic [7:0] RAM_BANK1_HI   = 8'h7E;
    localparam logic [7:0] RAM_BANK2_LO   = 8'h80;
    localparam logic [7:0] RAM_BANK2_HI   = 8'hFE;
    localparam logic [7:0] CLOCK_REG_LAST = 8'h0D;
    // Field positions
    localparam int VALID_BIT    = 7;
    localparam int SUMMARY_BIT  = 7;
    localparam int PERIODIC_BIT = 6;
    localparam int ALARM_BIT    = 5;
    localparam int UPDATE_BIT   = 4;
    localparam int DIV_LSB      = 4;
    localparam int RATE_LSB     = 0;
    // Divider control codes
    localparam logic [2:0] DIV_NORMAL    = 3'h2;
    localparam logic [2:0] DIV_RESET_MSB = 3'h6;
    // Reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    // Timing: 32.768 kHz tick cycles of post-power host lockout (0.5 ms .. 1 ms)
    localparam logic [5:0] LOCKOUT_TICKS = 6'h18;
    localparam int DIV_STAGES = 22;
    localparam int REF_CLK_HZ = 40000000;
endpackage

// ==== src/rtil_divider.sv ====
// 22-stage binary divider with periodic tap select and half-second first update
`timescale 1ns/1ps
`default_nettype none
module rtil_divider #(
    parameter int STAGES = 22
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Timebase tick and control
    input  wire logic       tbTick,
    input  wire logic       divRun,
    input  wire logic [3:0] rateSelect,
    // Events
    output logic            periodicEvent,
    output logic            secondEvent
);
    import rtil_pkg::*;

    initial begin
        if (STAGES < 16) begin
            $error("rtil_divider: STAGES too small for rate taps");
        end
    end

    logic [STAGES-1:0] divCnt_ff;
    logic [STAGES-1:0] nxt_divCnt;
    logic              periodic_ff;
    logic              nxt_periodic;
    logic              second_ff;
    logic              nxt_second;

    // Tap of the chain toggling at twice the periodic rate
    function automatic int tapOf(input logic [3:0] rs);
        int t;
        t = 0;
        if (rs == 4'h1) begin
            t = 6;
        end else if (rs == 4'h2) begin
            t = 7;
        end else if (rs != 4'h0) begin
            t = int'(rs) - 2;
        end
        return t;
    endfunction

    always_comb begin
        int tap;
        tap          = tapOf(rateSelect);
        nxt_divCnt   = divCnt_ff;
        nxt_periodic = 1'b0;
        nxt_second   = 1'b0;
        // reset stage is held, count starts at half second
        if (!divRun) begin
            nxt_divCnt = {1'b1, {(STAGES-1){1'b0}}} >> (STAGES - 15);
        end else if (tbTick) begin
            nxt_divCnt = divCnt_ff + {{(STAGES-1){1'b0}}, 1'b1};
            // rising edge on the chosen tap
            if (rateSelect != 4'h0) begin
                nxt_periodic = !divCnt_ff[tap] && nxt_divCnt[tap];
            end
            // 1 Hz tick at 2^15 timebase cycles
            nxt_second = (divCnt_ff[14:0] == 15'h7FFF);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            divCnt_ff   <= '0;
            periodic_ff <= 1'b0;
            second_ff   <= 1'b0;
        end else begin
            divCnt_ff   <= nxt_divCnt;
            periodic_ff <= nxt_periodic;
            second_ff   <= nxt_second;
        end
    end

    assign periodicEvent = periodic_ff;
    assign secondEvent   = second_ff;
endmodule
`default_nettype wire

// ==== sim/rtil_monitor.sv ====
// Checker: readback, interrupt and lockout relations at the core ports
`timescale 1ns/1ps
`default_nettype none
module rtil_monitor
    import rtil_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Power pins
    input wire logic       host_rail,
    input wire logic       power_ok_input,
    input wire logic       main_rail,
    input wire logic       battery_rail_fresh,
    input wire logic       controller_init,
    // Register ports
    input wire logic       hostRd,
    input wire logic       hostWr,
    input wire logic [7:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic       ctlRd,
    input wire logic       ctlWr,
    // Outputs
    input wire logic [7:0] rdData,
    input wire logic       clock_irq_n,
    input wire logic       host_write_lockout,
    input wire logic       controller_write_lockout,
    input wire logic       oscillatorOn
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic rdFlags = hostRd && hostAddr == REG_FLAGS;
    wire logic rdValid = hostRd && hostAddr == REG_VALID;
    wire logic anyAcc  = hostRd || ctlRd || hostWr || ctlWr;
    wire logic offAll  = hostWr && !ctlWr && !host_write_lockout && hostAddr == REG_CTRL_B
                         && hostWdata[6:4] == 3'h0;
    //////////////////////////////////////////////////////////////////////////
    valid_low_a: assert property (rdValid |=> rdData[6:0] == 7'h00)
        else $error("valid register low bits not zero");
    flag_low_a: assert property (rdFlags |=> rdData[3:0] == 4'h0)
        else $error("flag register low bits not zero");
    summary_match_a: assert property (rdFlags |=> rdData[7] == !$past(clock_irq_n))
        else $error("summary flag disagrees with interrupt line");
    irq_clear_a: assert property (rdFlags |=> clock_irq_n)
        else $error("interrupt still low after flag read");
    irq_disable_a: assert property (offAll |=> clock_irq_n)
        else $error("interrupt low with all enables off");
    irq_hold_a: assert property (!clock_irq_n && !anyAcc |=> !clock_irq_n)
        else $error("interrupt released without read or disable");
    host_lock_a: assert property ((!host_rail || !power_ok_input)[*5] |-> host_write_lockout)
        else $error("host writes open while power is bad");
    ctl_lock_a: assert property ((!main_rail || controller_init)[*5] |-> controller_write_lockout)
        else $error("controller writes open while rail low or in init");
    host_release_a: assert property ($fell(host_write_lockout) |->
        host_rail && power_ok_input && !controller_write_lockout)
        else $error("host lockout released too early");
    osc_stop_a: assert property ((battery_rail_fresh && !main_rail)[*5] |-> !oscillatorOn)
        else $error("oscillator running after fresh battery");
    cover property (rdFlags ##1 rdData[6]);
    cover property ($fell(host_write_lockout));
    cover property ($fell(clock_irq_n));
endmodule
bind rtil_core rtil_monitor mon_u (
    .ref_clk(ref_clk), .reset(reset), .host_rail(host_rail),
    .power_ok_input(power_ok_input), .main_rail(main_rail),
    .battery_rail_fresh(battery_rail_fresh), .controller_init(controller_init),
    .hostRd(hostRd), .hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata),
    .ctlRd(ctlRd), .ctlWr(ctlWr), .rdData(rdData), .clock_irq_n(clock_irq_n),
    .host_write_lockout(host_write_lockout),
    .controller_write_lockout(controller_write_lockout), .oscillatorOn(oscillatorOn)
);
`default_nettype wire

// ==== sim/rtil_timebase_model.sv ====
// Timebase source standing in for the slow crystal
`timescale 1ns/1ps
`default_nettype none
module rtil_timebase_model #(
    parameter int HALF = 10
) (
    // Reference clock
    input  wire logic ref_clk,
    // Square wave out
    output var logic  timebase
);
    int cnt = 0;
    initial timebase = 1'b0;
    // Shortened period keeps lockout and periodic runs to under a thousand cycles
    always @(negedge ref_clk) begin
        cnt = cnt + 1;
        if (cnt == HALF) begin
            cnt = 0;
            timebase = ~timebase;
        end
    end
endmodule
`default_nettype wire

// ==== sim/rtc_irq_and_power_lockout_test.sv ====
// Testbench: valid flag, RAM, interrupt merge and power lockouts
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_and_power_lockout_test;
    import rtil_pkg::*;
    localparam int TBP = 2;
    localparam int LIMIT = 40000;
    logic       ref_clk, reset, timebase, hostRail, powerOk, mainRail, batFresh, ctlInit;
    logic       hostRd, hostWr, ctlRd, ctlWr, irqN, hostLock, ctlLock, oscOn, alarmIn, updIn;
    logic [7:0] hostAddr, hostWdata, ctlAddr, ctlWdata, rdData;
    int         miscompares = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         n;
    rtil_timebase_model #(.HALF(TBP / 2)) tb_u (.ref_clk(ref_clk), .timebase(timebase));
    rtil_core dut_u (
        .ref_clk(ref_clk), .reset(reset), .timebase(timebase), .alarm_match(alarmIn),
        .update_done(updIn), .host_rail(hostRail), .power_ok_input(powerOk),
        .main_rail(mainRail), .battery_rail_fresh(batFresh), .controller_init(ctlInit),
        .hostRd(hostRd), .hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata),
        .ctlRd(ctlRd), .ctlWr(ctlWr), .ctlAddr(ctlAddr), .ctlWdata(ctlWdata),
        .rdData(rdData), .clock_irq_n(irqN), .host_write_lockout(hostLock),
        .controller_write_lockout(ctlLock), .oscillatorOn(oscOn)
    );
    //////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ctl, input logic [7:0] a, input logic [7:0] d);
        hostWr = !ctl;
        ctlWr = ctl;
        hostAddr = a;
        ctlAddr = a;
        hostWdata = d;
        ctlWdata = d;
        @(negedge ref_clk);
        hostWr = 1'b0;
        ctlWr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic ctl, input logic [7:0] a, input logic [7:0] exp);
        hostRd = !ctl;
        ctlRd = ctl;
        hostAddr = a;
        ctlAddr = a;
        @(negedge ref_clk);
        hostRd = 1'b0;
        ctlRd = 1'b0;
        chk(rdData, exp);
        @(negedge ref_clk);
    endtask
    task automatic wait_unlock(input int lim);
        n = 0;
        while ((hostLock !== 1'b0 || ctlLock !== 1'b0) && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic test_valid();
        wr(0, REG_VALID, 8'hFF);
        rd(0, REG_VALID, 8'h00);
        rd(0, REG_VALID, 8'h80);
        rd(1, REG_VALID, 8'h80);
        $display("test_valid done");
    endtask
    task automatic test_ram();
        logic [7:0] adr [4];
        adr = '{RAM_BANK1_LO, RAM_BANK1_HI, RAM_BANK2_LO, RAM_BANK2_HI};
        for (int i = 0; i < 4; i++)
            wr(i[0], adr[i], 8'hA0 + 8'(i));
        for (int i = 0; i < 4; i++)
            rd(!i[0], adr[i], 8'hA0 + 8'(i));
        $display("test_ram done");
    endtask
    task automatic test_irq();
        wr(0, REG_CTRL_A, 8'h23);
        wr(0, REG_CTRL_B, 8'h00);
        repeat (6 * TBP) @(negedge ref_clk);
        chk({7'h00, irqN}, 8'h01);
        rd(0, REG_FLAGS, 8'h40);
        repeat (6 * TBP) @(negedge ref_clk);
        wr(0, REG_CTRL_B, 8'h40);
        chk({7'h00, irqN}, 8'h00);
        rd(0, REG_FLAGS, 8'hC0);
        chk({7'h00, irqN}, 8'h01);
        wr(0, REG_CTRL_B, 8'h00);
        $display("test_irq done");
    endtask
    task automatic test_host_lock();
        powerOk = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk({7'h00, hostLock}, 8'h01);
        wr(0, RAM_BANK1_LO, 8'h5A);
        powerOk = 1'b1;
        wait_unlock(40 * TBP);
        chk({7'h00, n >= 17 * TBP && n <= 33 * TBP}, 8'h01);
        rd(0, RAM_BANK1_LO, 8'hA0);
        wr(0, REG_CTRL_A, 8'h60);
        powerOk = 1'b0;
        repeat (8) @(negedge ref_clk);
        powerOk = 1'b1;
        wait_unlock(40 * TBP);
        chk({7'h00, n < 4 * TBP}, 8'h01);
        wr(0, REG_CTRL_A, 8'h23);
        $display("test_host_lock done");
    endtask
    task automatic test_ctl_lock();
        ctlInit = 1'b1;
        powerOk = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk({6'h00, hostLock, ctlLock}, 8'h03);
        wr(1, RAM_BANK2_LO, 8'h33);
        powerOk = 1'b1;
        repeat (40 * TBP) @(negedge ref_clk);
        chk({7'h00, hostLock}, 8'h01);
        ctlInit = 1'b0;
        wait_unlock(4 * TBP);
        chk({7'h00, n < 4 * TBP}, 8'h01);
        rd(1, RAM_BANK2_LO, 8'hA2);
        $display("test_ctl_lock done");
    endtask
    task automatic test_battery();
        mainRail = 1'b0;
        batFresh = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk({7'h00, oscOn}, 8'h00);
        mainRail = 1'b1;
        batFresh = 1'b0;
        wait_unlock(40 * TBP);
        rd(0, REG_CTRL_A, 8'h00);
        rd(0, REG_VALID, 8'h00);
        $display("test_battery done");
    endtask
    task automatic test_update();
        alarmIn = 1'b1;
        updIn = 1'b1;
        rd(0, REG_FLAGS, 8'h40);
        wr(0, REG_CTRL_B, 8'h30);
        wr(0, REG_CTRL_A, 8'h60);
        wr(0, REG_CTRL_A, 8'h20);
        n = 0;
        while (irqN !== 1'b0 && n < 17000 * TBP) begin
            @(negedge ref_clk);
            n++;
        end
        chk({7'h00, n >= 16382 * TBP && n <= 16386 * TBP}, 8'h01);
        rd(0, REG_FLAGS, 8'hB0);
        chk({7'h00, irqN}, 8'h01);
        alarmIn = 1'b0;
        updIn = 1'b0;
        wr(0, REG_CTRL_B, 8'h00);
        $display("test_update done");
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        {hostRd, hostWr, ctlRd, ctlWr, batFresh, ctlInit, alarmIn, updIn} = 8'h00;
        {hostAddr, hostWdata, ctlAddr, ctlWdata} = 32'h0000_0000;
        {hostRail, powerOk, mainRail, reset} = 4'hF;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        wait_unlock(40 * TBP);
        test_valid();
        test_ram();
        test_irq();
        test_host_lock();
        test_ctl_lock();
        test_battery();
        test_update();
        give_verdict();
    end
endmodule
`default_nettype wire
